// ===== shared/atf_params.svh
/*
 Frame layout constants for the transmit-request frame parser.
 Assumes inclusion by bare name from the design files.
*/
// Summary of operation
// - frame opens with delimiter 0x7e, then a two-byte length, high byte first.
// - length counts bytes after the length field and before the checksum.
// - frame type 0x10 at offset 3 orders a radio send to the destination.
// - offset 4 holds frame id; id zero means no response frame.
// - destination 0x000000000000ffff is treated as broadcast.
// - offset 15 is broadcast hop limit; zero selects the configured maximum.
// - option bit 0 disables ack, bit 1 skips route discovery; others zero.
// - bytes from offset 17 to before checksum are payload, passed unchanged.
// - sum of bytes from offset 3 through checksum must equal 0xff.
// - escape mode 1 carries all bytes unescaped.
// - escape mode 2 restores escaped bytes before length and checksum checks.
// - status frame follows each send unless the frame id was zero.
`ifndef ATF_PARAMS_SVH
`define ATF_PARAMS_SVH
`define ATF_DELIM 8'h7e
`define ATF_ESC 8'h7d
`define ATF_ESC_XOR 8'h20
`define ATF_TYPE_TX 8'h10
`define ATF_SUM_OK 8'hff
`define ATF_BCAST_ADDR 64'h0000_0000_0000_ffff
`define ATF_HDR_LEN 16'h000e
`define ATF_OFS_TYPE 16'h0000
`define ATF_OFS_ID 16'h0001
`define ATF_OFS_DST_LO 16'h0009
`define ATF_OFS_RSV_LO 16'h000b
`define ATF_OFS_RADIUS 16'h000c
`define ATF_OFS_OPT 16'h000d
`define ATF_MODE_ESC 2'h2
`define ATF_FIFO_DEPTH 32
`endif

// ===== shared/atf_pkg.sv
/*
 Types shared by the frame parser, its assertions and its bench.
 Assumes atf_params.svh is on the include path.
*/
package atf_pkg;
   typedef enum logic [2:0] {
      ATF_HUNT = 3'b000,
      ATF_LEN_HI = 3'b001,
      ATF_LEN_LO = 3'b010,
      ATF_BODY = 3'b011,
      ATF_CSUM = 3'b100
   } atf_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } atf_beat_t;

   typedef struct packed {
      logic [63:0] dest;
      logic [7:0] frame_id;
      logic [7:0] radius;
      logic broadcast;
      logic no_ack;
      logic no_route_disc;
      logic want_status;
      logic [15:0] payload_len;
   } atf_req_t;
endpackage

// ===== verilog/atf_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module atf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic do_wr;
   logic do_rd;

   assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign out_data_o = mem_ff[rd_ptr_ff];
   assign do_wr = in_valid_i && in_ready_o;
   assign do_rd = out_valid_o && out_ready_i;

   always_ff @(posedge clk_sys_i) begin
      if (do_wr) begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count_ff <= count_ff + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/atf_framer.sv
/*
 Transmit-request frame parser: takes host bytes, deescapes them in escape mode 2, checks length
 and checksum, sends payload through a FIFO and the request fields out.
 Assumes bytes arrive already deserialised on the system clock.
 Assumes the escape mode only changes between frames.
 Assumes the consumer drops buffered payload of a frame that ends in
 frame_err_o; unescaped mode has no resync inside a frame.
*/
`timescale 1ns/10ps
`default_nettype none
`include "atf_params.svh"
module atf_framer #(
   parameter int FIFO_DEPTH = `ATF_FIFO_DEPTH
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [1:0] api_escape_mode_setting_i,
   input wire logic [7:0] max_hops_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   output atf_pkg::atf_beat_t pay_data_o,
   output logic pay_valid_o,
   input wire logic pay_ready_i,
   output atf_pkg::atf_req_t req_o,
   output logic req_valid_o,
   output logic frame_err_o
);
   import atf_pkg::*;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   atf_state_t state_ff;
   logic esc_ff;
   logic [15:0] len_ff;
   logic [15:0] idx_ff;
   logic [7:0] sum_ff;
   logic [7:0] type_ff;
   atf_req_t req_ff;
   logic req_valid_ff;
   logic err_ff;
   logic fifo_in_ready;
   atf_beat_t fifo_in;
   logic fifo_in_valid;

   // -------------------------------------------------------------
   // input decode
   // -------------------------------------------------------------
   logic take;
   logic is_delim;
   logic is_esc_lead;
   logic [7:0] byte_d;
   logic in_payload;
   logic good_sum;

   function automatic logic [7:0] unesc(input logic [7:0] b, input logic e);
      unesc = e ? (b ^ `ATF_ESC_XOR) : b;
   endfunction

   // body byte that closes the counted span
   function automatic logic body_end(input logic [15:0] idx,
      input logic [15:0] len);
      body_end = (idx + 16'h0001 == len);
   endfunction

   function automatic logic bcast_dest(input logic [63:0] d);
      bcast_dest = (d == `ATF_BCAST_ADDR);
   endfunction

   function automatic logic [7:0] hop_limit(input logic [7:0] b,
      input logic [7:0] cfg);
      hop_limit = (b == 8'h00) ? cfg : b;
   endfunction

   // only a payload byte waits on a full buffer
   assign rx_ready_o = (state_ff != ATF_BODY) || !in_payload || fifo_in_ready;
   assign take = rx_valid_i && rx_ready_o;
   // unescaped bytes may equal the delimiter, so resync only while hunting
   assign is_delim = (rx_byte_i == `ATF_DELIM)
      && ((api_escape_mode_setting_i == `ATF_MODE_ESC)
      || (state_ff == ATF_HUNT));
   assign is_esc_lead = (api_escape_mode_setting_i == `ATF_MODE_ESC)
      && (rx_byte_i == `ATF_ESC) && !esc_ff;
   assign byte_d = unesc(rx_byte_i, esc_ff);
   assign in_payload = (idx_ff > `ATF_OFS_OPT);
   assign good_sum = (8'(sum_ff + byte_d) == `ATF_SUM_OK);

   // remembers an escape lead until the byte it modifies
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         esc_ff <= 1'b0;
      end else if (take) begin
         esc_ff <= is_esc_lead;
      end
   end

   // -------------------------------------------------------------
   // frame walk
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         state_ff <= ATF_HUNT;
         len_ff <= 16'h0000;
         idx_ff <= 16'h0000;
         sum_ff <= 8'h00;
         type_ff <= 8'h00;
      end else if (take && is_delim) begin
         state_ff <= ATF_LEN_HI;
      end else if (take && !is_esc_lead) begin
         unique case (state_ff)
            ATF_HUNT: begin
            end
            ATF_LEN_HI: begin
               len_ff <= {byte_d, 8'h00};
               state_ff <= ATF_LEN_LO;
            end
            ATF_LEN_LO: begin
               len_ff <= {len_ff[15:8], byte_d};
               idx_ff <= 16'h0000;
               sum_ff <= 8'h00;
               // header is fixed; shorter length cannot be a request
               state_ff <= ({len_ff[15:8], byte_d} < `ATF_HDR_LEN + 16'h0001)
                  ? ATF_HUNT : ATF_BODY;
            end
            ATF_BODY: begin
               sum_ff <= 8'(sum_ff + byte_d);
               idx_ff <= idx_ff + 16'h0001;
               if (idx_ff == `ATF_OFS_TYPE) begin
                  type_ff <= byte_d;
               end
               if (body_end(idx_ff, len_ff)) begin
                  state_ff <= ATF_CSUM;
               end
            end
            ATF_CSUM: begin
               state_ff <= ATF_HUNT;
            end
            default: state_ff <= ATF_HUNT;
         endcase
      end
   end

   // -------------------------------------------------------------
   // field capture
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         req_ff <= '0;
      end else if (take && !is_esc_lead && !is_delim
                   && state_ff == ATF_BODY) begin
         if (idx_ff == `ATF_OFS_ID) begin
            req_ff.frame_id <= byte_d;
         end
         if (idx_ff > `ATF_OFS_ID && idx_ff <= `ATF_OFS_DST_LO) begin
            req_ff.dest <= {req_ff.dest[55:0], byte_d};
         end
         if (idx_ff == `ATF_OFS_RADIUS) begin
            req_ff.radius <= hop_limit(byte_d, max_hops_i);
         end
         if (idx_ff == `ATF_OFS_OPT) begin
            req_ff.no_ack <= byte_d[0];
            req_ff.no_route_disc <= byte_d[1];
         end
         req_ff.payload_len <= len_ff - `ATF_HDR_LEN;
         req_ff.broadcast <= bcast_dest(req_ff.dest);
         req_ff.want_status <= (req_ff.frame_id != 8'h00);
      end else if (state_ff == ATF_CSUM) begin
         // flags settle from the final captured fields
         req_ff.broadcast <= bcast_dest(req_ff.dest);
         req_ff.want_status <= (req_ff.frame_id != 8'h00);
      end
   end

   // -------------------------------------------------------------
   // verdict
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         req_valid_ff <= 1'b0;
      end else begin
         req_valid_ff <= take && !is_esc_lead && !is_delim
            && state_ff == ATF_CSUM && good_sum
            && type_ff == `ATF_TYPE_TX;
      end
   end

   // a delimiter inside a frame cuts it
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         err_ff <= 1'b0;
      end else begin
         err_ff <= (take && !is_esc_lead && !is_delim
            && state_ff == ATF_CSUM && !good_sum)
            || (take && is_delim && state_ff != ATF_HUNT);
      end
   end

   assign req_o = req_ff;
   assign req_valid_o = req_valid_ff;
   assign frame_err_o = err_ff;

   // -------------------------------------------------------------
   // payload path
   // -------------------------------------------------------------
   assign fifo_in.data = byte_d;
   assign fifo_in.last = body_end(idx_ff, len_ff);
   // other frame types are checked but never buffered
   assign fifo_in_valid = rx_valid_i && state_ff == ATF_BODY && in_payload
      && !is_esc_lead && !is_delim && (type_ff == `ATF_TYPE_TX);

   atf_fifo #(
      .WIDTH($bits(atf_beat_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .in_data_i(fifo_in),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .out_data_o(pay_data_o),
      .out_valid_o(pay_valid_o),
      .out_ready_i(pay_ready_i)
   );
endmodule
`default_nettype wire

// ===== dv/atf_framer_properties.sv
/* assertions on the framer's ports
   bound from the bench top; one clock, sync active-low reset */
`timescale 1ns/10ps
`default_nettype none
module atf_framer_properties (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [7:0] max_hops_i,
   input wire logic rx_valid_i,
   input wire logic rx_ready_o,
   input wire atf_pkg::atf_beat_t pay_data_o,
   input wire logic pay_valid_o,
   input wire logic pay_ready_i,
   input wire atf_pkg::atf_req_t req_o,
   input wire logic req_valid_o,
   input wire logic frame_err_o
);
   import atf_pkg::*;
   // ----------
   // properties
   // ----------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_no_take;
      !(rx_valid_i && rx_ready_o);
   endsequence
   sequence s_stall;
      pay_valid_o && !pay_ready_i;
   endsequence
   answer_slot_a: assert property (
      s_no_take |=> !req_valid_o && !frame_err_o)
      else $error("outcome without a taken byte");
   outcome_excl_a: assert property (!(req_valid_o && frame_err_o))
      else $error("request and error together");
   req_pulse_a: assert property (req_valid_o |=> !req_valid_o)
      else $error("request pulse too long");
   bcast_flag_a: assert property (
      req_valid_o |-> req_o.broadcast == (req_o.dest == 64'hffff))
      else $error("broadcast flag wrong");
   radius_fill_a: assert property (
      req_valid_o && max_hops_i != 8'h00 |-> req_o.radius != 8'h00)
      else $error("zero radius passed on");
   status_flag_a: assert property (
      req_valid_o |-> req_o.want_status == (req_o.frame_id != 8'h00))
      else $error("status flag wrong");
   pay_hold_a: assert property (
      s_stall |=> pay_valid_o && $stable(pay_data_o))
      else $error("payload changed while stalled");
   ready_full_a: assert property (!rx_ready_o |-> pay_valid_o)
      else $error("refusal with empty buffer");
endmodule
`default_nettype wire

// ===== dv/atf_host.sv
/* host model: offers link bytes, escapes them on request
   assumes tasks are called just after a rising clock edge */
`timescale 1ns/10ps
`default_nettype none
module atf_host (
   input wire logic clk_sys_i,
   input wire logic rx_ready_i,
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o
);
   // -----
   // tasks
   // -----
   initial begin
      rx_byte_o = 8'h00;
      rx_valid_o = 1'b0;
   end
   task automatic put(input logic [7:0] b);
      logic rdy;
      rx_byte_o <= b;
      rx_valid_o <= 1'b1;
      do begin
         @(negedge clk_sys_i);
         rdy = rx_ready_i;
         @(posedge clk_sys_i);
      end while (rdy !== 1'b1);
   endtask
   task automatic put_esc(input logic [7:0] b, input bit esc);
      if (esc && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13)) begin
         put(8'h7d);
         put(b ^ 8'h20);
      end else begin
         put(b);
      end
   endtask
   // released line shows the inverse of its last value
   task automatic idle();
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~rx_byte_o;
      @(posedge clk_sys_i);
   endtask
endmodule
`default_nettype wire

// ===== dv/atf_framer_tb_top.sv
/* bench top: host model feeds hand-made and random frames
   assumes package, design, host model and checker compiled first */
`timescale 1ns/10ps
`default_nettype none
module atf_framer_tb_top;
   import atf_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [1:0] api_escape_mode_setting_i = 2'h1;
   logic [7:0] max_hops_i = 8'h0f;
   logic [7:0] rx_byte_i;
   logic rx_valid_i;
   logic rx_ready_o;
   atf_beat_t pay_data_o;
   logic pay_valid_o;
   logic pay_ready_i = 1'b0;
   atf_req_t req_o;
   logic req_valid_o;
   logic frame_err_o;
   int seed = 32'h30f4;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int exp_err = 0;
   int err_seen = 0;
   bit stall = 1'b0;
   atf_beat_t exp_pay[$];
   atf_req_t exp_req[$];
   logic [7:0] cut[4] = '{8'h7e, 8'h00, 8'h16, 8'h10};
   // -----------------
   // design and checks
   // -----------------
   atf_framer #(.FIFO_DEPTH(32)) i_atf_framer (.clk_sys_i, .rst_b_i,
      .api_escape_mode_setting_i, .max_hops_i, .rx_byte_i, .rx_valid_i,
      .rx_ready_o, .pay_data_o, .pay_valid_o, .pay_ready_i, .req_o,
      .req_valid_o, .frame_err_o);
   atf_host i_atf_host (.clk_sys_i, .rx_ready_i(rx_ready_o),
      .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i));
   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   task automatic close_out();
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp_beat(input atf_beat_t got, input atf_beat_t exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t beat %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_req(input atf_req_t got, input atf_req_t exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t req %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_int(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         bad_count++;
         $display("ERROR %0t count %0d exp %0d", $time, got, exp);
      end
   endtask
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      pay_ready_i <= !stall && ($random(seed) % 3 != 0);
      err_seen <= err_seen + int'(frame_err_o === 1'b1);
      if (rst_b_i && pay_valid_o && pay_ready_i)
         cmp_beat(pay_data_o, exp_pay.pop_front());
      if (req_valid_o === 1'b1)
         cmp_req(req_o, exp_req.pop_front());
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic send_frame(input logic [7:0] typ, id, rad, opt, p0,
         input logic [63:0] dst, input int n, input bit bad);
      logic [7:0] body[$];
      logic [7:0] b;
      logic [7:0] sum;
      logic [15:0] len;
      atf_req_t r;
      bit esc;
      esc = api_escape_mode_setting_i == 2'h2;
      body = {typ, id};
      for (int i = 7; i >= 0; i--) body.push_back(dst[i*8 +: 8]);
      body = {body, 8'hff, 8'hfe, rad, opt};
      for (int i = 0; i < n; i++) begin
         b = i ? 8'($random(seed)) : p0;
         body.push_back(b);
         if (typ == 8'h10) exp_pay.push_back({b, i == n - 1});
      end
      sum = 8'h00;
      foreach (body[k]) sum += body[k];
      len = 16'(body.size());
      body.push_back((8'hff - sum) ^ {7'h0, bad});
      r = '{dst, id, rad ? rad : max_hops_i, dst == 64'hffff, opt[0], opt[1],
         id != 8'h00, 16'(n)};
      if (bad) exp_err++;
      else if (typ == 8'h10) exp_req.push_back(r);
      i_atf_host.put(8'h7e);
      i_atf_host.put_esc(len[15:8], esc);
      i_atf_host.put_esc(len[7:0], esc);
      foreach (body[k]) i_atf_host.put_esc(body[k], esc);
      i_atf_host.idle();
   endtask
   initial begin
      repeat (12) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      @(posedge clk_sys_i);
      i_atf_host.put(8'h55);
      send_frame(8'h10, 8'h01, 8'h00, 8'h00, 8'h7d, 64'h0013a200400a0127,
         1, 1'b0);
      send_frame(8'h10, 8'h00, 8'h7e, 8'h02, 8'h7e, 64'h7e00_0000_0000_007e,
         2, 1'b0);
      foreach (cut[k]) i_atf_host.put(cut[k]);
      i_atf_host.idle();
      exp_err++;
      api_escape_mode_setting_i <= 2'h2;
      @(posedge clk_sys_i);
      send_frame(8'h10, 8'h00, 8'h00, 8'h03, 8'h13, 64'hffff, 5, 1'b1);
      send_frame(8'h10, 8'h00, 8'h00, 8'h03, 8'h13, 64'hffff, 5, 1'b0);
      send_frame(8'h08, 8'h02, 8'h00, 8'h00, 8'h11, 64'h7e, 3, 1'b0);
      stall <= 1'b1;
      fork
         send_frame(8'h10, 8'h07, 8'h09, 8'h01, 8'h7e, 64'h1234, 40,
            1'b0);
         begin
            repeat (120) @(posedge clk_sys_i);
            cmp_int(int'(rx_ready_o === 1'b0), 1);
            stall <= 1'b0;
         end
      join
      for (int f = 0; f < 40; f++) begin
         max_hops_i <= 8'($random(seed)) | 8'h01;
         @(posedge clk_sys_i);
         send_frame(($random(seed) & 3) ? 8'h10 : 8'h08, 8'($random(seed)),
            ($random(seed) & 1) ? 8'($random(seed)) : 8'h00,
            8'($random(seed) & 3), 8'($random(seed)),
            ($random(seed) & 1) ? 64'hffff : {$random(seed), $random(seed)},
            1 + ($random(seed) & 15), 1'b0);
      end
      for (int k = 0; k < 3000 && (exp_pay.size() || exp_req.size()
            || err_seen != exp_err); k++) @(posedge clk_sys_i);
      cmp_int(exp_req.size(), 0);
      cmp_int(err_seen, exp_err);
      cmp_int(exp_pay.size(), 0);
      close_out();
   end
endmodule
bind atf_framer atf_framer_properties i_atf_framer_properties (.clk_sys_i,
   .rst_b_i, .max_hops_i, .rx_valid_i, .rx_ready_o, .pay_data_o,
   .pay_valid_o, .pay_ready_i, .req_o, .req_valid_o, .frame_err_o);
`default_nettype wire
